// ### design/vcr_regs.sv
// volatile configuration status register bank with core and link clock domains
`timescale 1ns/1ps
module vcr_regs (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic link_clk,
    input wire vcr_pkg::vcr_event_type core_event,
    input wire vcr_pkg::vcr_access_type host_access,
    output logic [7:0] read_data,
    output logic read_valid,
    output logic reject_flag_set,
    output logic wel_clear,
    output logic [7:0] config_byte
);
    import vcr_pkg::*;

    // ****************************************
    // core domain declarations
    // ****************************************
    logic [1:0] cfg_s1_reg;
    logic [1:0] cfg_s2_reg;
    logic ack_s1_reg;
    logic ack_s2_reg;
    logic [3:0] correction_event_tally_reg;
    logic [3:0] correction_event_tally_next;
    logic incremental_program_attempt_flag_reg;
    logic incremental_program_attempt_flag_next;
    logic double_bit_error_flag_reg;
    logic double_bit_error_flag_next;
    logic address_parity_error_flag_reg;
    logic address_parity_error_flag_next;
    logic array_crc_error_flag_reg;
    logic array_crc_error_flag_next;
    logic [27:0] first_event_chunk_address_reg;
    logic [27:0] first_event_chunk_address_next;
    logic captured_reg;
    logic captured_next;
    logic [2:0] active_bank_field_reg;
    logic [2:0] active_bank_field_next;
    logic snap_req_reg;
    logic snap_req_next;
    vcr_status_type snap_data_reg;
    vcr_status_type snap_data_next;
    logic ecc_on;
    logic select_double;
    logic ecc_hit;
    logic capture_hit;
    logic [7:0] status_byte;

    // ****************************************
    // link domain declarations
    // ****************************************
    logic [7:0] config_reg;
    logic [7:0] config_next;
    logic req_s1_reg;
    logic req_s2_reg;
    logic snap_ack_reg;
    logic snap_ack_next;
    vcr_status_type shadow_reg;
    vcr_status_type shadow_next;
    logic [7:0] read_data_reg;
    logic [7:0] read_data_next;
    logic read_valid_reg;
    logic read_valid_next;
    logic reject_reg;
    logic reject_next;
    logic wel_clear_reg;
    logic wel_clear_next;
    logic [7:0] reg_index;

    // ****************************************
    // core domain synchronisers
    // ****************************************
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg_s1_reg <= {VCR_CONFIG_RESET[VCR_SELECT_POS], VCR_CONFIG_RESET[VCR_DISABLE_POS]};
            cfg_s2_reg <= {VCR_CONFIG_RESET[VCR_SELECT_POS], VCR_CONFIG_RESET[VCR_DISABLE_POS]};
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end
        else
        begin
            cfg_s1_reg <= {config_reg[VCR_SELECT_POS], config_reg[VCR_DISABLE_POS]};
            cfg_s2_reg <= cfg_s1_reg;
            ack_s1_reg <= snap_ack_reg;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    // ****************************************
    // core domain status next values
    // ****************************************
    always_comb
    begin
        ecc_on = ~cfg_s2_reg[0];
        select_double = cfg_s2_reg[1];
        ecc_hit = ecc_on & (core_event.ecc_single | core_event.ecc_double);
        capture_hit = ecc_on & ~captured_reg
            & (select_double ? core_event.ecc_double : core_event.ecc_single);
        correction_event_tally_next = correction_event_tally_reg;
        if (ecc_hit && correction_event_tally_reg != VCR_TALLY_MAX)
        begin
            correction_event_tally_next = correction_event_tally_reg + VCR_TALLY_ONE;
        end
        first_event_chunk_address_next = first_event_chunk_address_reg;
        captured_next = captured_reg;
        if (capture_hit)
        begin
            first_event_chunk_address_next = core_event.chunk_addr;
            captured_next = 1'b1;
        end
        incremental_program_attempt_flag_next = incremental_program_attempt_flag_reg
            | core_event.incr_program;
        double_bit_error_flag_next = double_bit_error_flag_reg
            | (ecc_on & core_event.ecc_double);
        address_parity_error_flag_next = address_parity_error_flag_reg
            | core_event.parity_err;
        array_crc_error_flag_next = array_crc_error_flag_reg
            | core_event.crc_err | core_event.boundary_err;
        active_bank_field_next = core_event.bank_busy
            ? {1'b1, core_event.bank_num} : VCR_BANK_IDLE;
    end

    // ****************************************
    // core domain snapshot handshake
    // ****************************************
    always_comb
    begin
        status_byte = VCR_STATUS_RESET;
        status_byte[VCR_INCR_POS] = incremental_program_attempt_flag_reg;
        status_byte[VCR_TALLY_MSB:VCR_TALLY_LSB] = correction_event_tally_reg;
        status_byte[VCR_DOUBLE_POS] = double_bit_error_flag_reg;
        status_byte[VCR_PARITY_POS] = address_parity_error_flag_reg;
        status_byte[VCR_CRC_POS] = array_crc_error_flag_reg;
        snap_req_next = snap_req_reg;
        snap_data_next = snap_data_reg;
        // new word only once the link side has taken the last one
        if (ack_s2_reg == snap_req_reg)
        begin
            snap_data_next.status = status_byte;
            snap_data_next.chunk = first_event_chunk_address_reg;
            snap_data_next.bank = active_bank_field_reg;
            snap_req_next = ~snap_req_reg;
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            correction_event_tally_reg <= VCR_TALLY_RESET;
            incremental_program_attempt_flag_reg <= 1'b0;
            double_bit_error_flag_reg <= 1'b0;
            address_parity_error_flag_reg <= 1'b0;
            array_crc_error_flag_reg <= 1'b0;
            first_event_chunk_address_reg <= VCR_CHUNK_RESET;
            captured_reg <= 1'b0;
            active_bank_field_reg <= VCR_BANK_IDLE;
        end
        else
        begin
            correction_event_tally_reg <= correction_event_tally_next;
            incremental_program_attempt_flag_reg <= incremental_program_attempt_flag_next;
            double_bit_error_flag_reg <= double_bit_error_flag_next;
            address_parity_error_flag_reg <= address_parity_error_flag_next;
            array_crc_error_flag_reg <= array_crc_error_flag_next;
            first_event_chunk_address_reg <= first_event_chunk_address_next;
            captured_reg <= captured_next;
            active_bank_field_reg <= active_bank_field_next;
        end
    end

    // ****************************************
    // core domain snapshot registers
    // ****************************************
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            snap_req_reg <= 1'b0;
            snap_data_reg <= VCR_SNAP_RESET;
        end
        else
        begin
            snap_req_reg <= snap_req_next;
            snap_data_reg <= snap_data_next;
        end
    end

    // ****************************************
    // link domain request synchroniser
    // ****************************************
    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
        end
        else
        begin
            req_s1_reg <= snap_req_reg;
            req_s2_reg <= req_s1_reg;
        end
    end

    // ****************************************
    // link domain snapshot capture
    // ****************************************
    always_comb
    begin
        shadow_next = shadow_reg;
        snap_ack_next = snap_ack_reg;
        // word is stable while request and acknowledge differ
        if (req_s2_reg != snap_ack_reg)
        begin
            shadow_next = snap_data_reg;
            snap_ack_next = req_s2_reg;
        end
    end

    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            snap_ack_reg <= 1'b0;
            shadow_reg <= VCR_SNAP_RESET;
        end
        else
        begin
            snap_ack_reg <= snap_ack_next;
            shadow_reg <= shadow_next;
        end
    end

    // ****************************************
    // link domain register access
    // ****************************************
    always_comb
    begin
        reg_index = host_access.addr[7:0];
        config_next = config_reg;
        read_data_next = read_data_reg;
        read_valid_next = 1'b0;
        reject_next = 1'b0;
        wel_clear_next = 1'b0;
        if (host_access.valid && host_access.write)
        begin
            if (reg_index == VCR_IDX_CONFIG)
            begin
                config_next = host_access.wdata;
            end
            else
            begin
                reject_next = 1'b1;
                wel_clear_next = 1'b1;
            end
        end
        else if (host_access.valid)
        begin
            read_valid_next = 1'b1;
            case (reg_index)
                VCR_IDX_CONFIG: read_data_next = config_reg;
                VCR_IDX_STATUS: read_data_next = shadow_reg.status;
                VCR_IDX_ADDR_LOW: read_data_next = {shadow_reg.chunk[3:0], VCR_LOW_NIBBLE};
                VCR_IDX_ADDR_MID: read_data_next = shadow_reg.chunk[11:4];
                VCR_IDX_ADDR_UPPER: read_data_next = shadow_reg.chunk[19:12];
                VCR_IDX_ADDR_TOP: read_data_next = shadow_reg.chunk[27:20];
                VCR_IDX_BANK: read_data_next = {VCR_BANK_PAD, shadow_reg.bank};
                default: read_data_next = VCR_RESERVED_BYTE;
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            config_reg <= VCR_CONFIG_RESET;
            read_data_reg <= VCR_RESERVED_BYTE;
            read_valid_reg <= 1'b0;
            reject_reg <= 1'b0;
            wel_clear_reg <= 1'b0;
        end
        else
        begin
            config_reg <= config_next;
            read_data_reg <= read_data_next;
            read_valid_reg <= read_valid_next;
            reject_reg <= reject_next;
            wel_clear_reg <= wel_clear_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign read_data = read_data_reg;
    assign read_valid = read_valid_reg;
    assign reject_flag_set = reject_reg;
    assign wel_clear = wel_clear_reg;
    assign config_byte = config_reg;

endmodule : vcr_regs

// ### design/vcr_pkg.sv
// constants and carrier types for the volatile configuration status registers
//
// Contract
// - after reset every configuration byte reads all ones unless a field says otherwise
// - only the lowest address byte selects one of up to 256 byte registers
// - reading any reserved address returns all ones
// - write of reserved setting is ignored, sets flag status bit 1, clears write enable; code stores any byte written to 0Bh, rejects writes to other indices
// - register 11h bits 2:0 show active bank: 000 none, 100..111 banks 0..3
// - registers 10h..0Dh capture chunk address bits 31:4 of first event
// - captured event kind is 1-bit correction or 2-bit detection per select bit
// - low nibble of register 0Dh always reads zero
// - 0Ch bit 7 sets on double or partial program within a chunk
// - 0Ch bits 6:3 count events from zero, saturating at 15
// - 0Ch bit 2 sets on any 2-bit error detection while correction is enabled (0Bh bit 0 zero)
// - 0Ch bit 1 sets on any address parity error
// - 0Ch bit 0 sets on array crc error or chunk boundary violation
// - select bit one (default) picks 2-bit detection, zero picks 1-bit correction
// - 0Bh bit 0 one (default) disables correction, zero enables it
package vcr_pkg;

    // ****************************************
    // register index and field layout
    // ****************************************
    localparam logic [7:0] VCR_IDX_CONFIG = 8'h0B;
    localparam logic [7:0] VCR_IDX_STATUS = 8'h0C;
    localparam logic [7:0] VCR_IDX_ADDR_LOW = 8'h0D;
    localparam logic [7:0] VCR_IDX_ADDR_MID = 8'h0E;
    localparam logic [7:0] VCR_IDX_ADDR_UPPER = 8'h0F;
    localparam logic [7:0] VCR_IDX_ADDR_TOP = 8'h10;
    localparam logic [7:0] VCR_IDX_BANK = 8'h11;
    localparam logic [7:0] VCR_RESERVED_BYTE = 8'hFF;
    localparam logic [7:0] VCR_CONFIG_RESET = 8'hFF;
    localparam logic [3:0] VCR_LOW_NIBBLE = 4'h0;
    localparam logic [4:0] VCR_BANK_PAD = 5'h00;
    localparam int VCR_DISABLE_POS = 0;
    localparam int VCR_SELECT_POS = 2;
    localparam int VCR_INCR_POS = 7;
    localparam int VCR_TALLY_MSB = 6;
    localparam int VCR_TALLY_LSB = 3;
    localparam int VCR_DOUBLE_POS = 2;
    localparam int VCR_PARITY_POS = 1;
    localparam int VCR_CRC_POS = 0;
    localparam logic [3:0] VCR_TALLY_MAX = 4'hF;
    localparam logic [3:0] VCR_TALLY_ONE = 4'h1;
    localparam logic [3:0] VCR_TALLY_RESET = 4'h0;
    localparam logic [2:0] VCR_BANK_IDLE = 3'h0;
    localparam logic [27:0] VCR_CHUNK_RESET = 28'h0000000;
    localparam logic [7:0] VCR_STATUS_RESET = 8'h00;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic ecc_single;
        logic ecc_double;
        logic [27:0] chunk_addr;
        logic parity_err;
        logic crc_err;
        logic boundary_err;
        logic incr_program;
        logic bank_busy;
        logic [1:0] bank_num;
    } vcr_event_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [7:0] wdata;
    } vcr_access_type;

    typedef struct packed {
        logic [7:0] status;
        logic [27:0] chunk;
        logic [2:0] bank;
    } vcr_status_type;

    localparam vcr_status_type VCR_SNAP_RESET = '{status: 8'h00, chunk: 28'h0000000, bank: 3'h0};

endpackage : vcr_pkg

// ### tb/vcr_regs_checker.sv
// assertions on the register access side of the status register bank
`timescale 1ns/1ps
module vcr_regs_checker
    import vcr_pkg::*;
(
    input wire logic link_clk,
    input wire logic reset_n,
    input wire vcr_pkg::vcr_access_type host_access,
    input wire logic [7:0] read_data,
    input wire logic read_valid,
    input wire logic reject_flag_set,
    input wire logic wel_clear,
    input wire logic [7:0] config_byte
);
    // ****************************************
    // access decode
    // ****************************************
    logic rd_req;
    logic wr_req;
    logic wr_cfg;
    logic [7:0] idx;
    assign rd_req = host_access.valid && !host_access.write;
    assign wr_req = host_access.valid && host_access.write;
    assign idx = host_access.addr[7:0];
    assign wr_cfg = wr_req && idx == VCR_IDX_CONFIG;
    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (!reset_n);
    // ****************************************
    // properties
    // ****************************************
    a_read_answer: assert property (rd_req |=> read_valid && !reject_flag_set)
        else $error("no read answer");
    a_data_hold: assert property (!rd_req |=> $stable(read_data)) else $error("read data moved");
    a_write_reject: assert property (wr_req && !wr_cfg |=> reject_flag_set && wel_clear)
        else $error("no reject");
    a_reject_pair: assert property (reject_flag_set == wel_clear) else $error("reject and clear apart");
    a_no_reject: assert property (!wr_req || wr_cfg |=> !reject_flag_set) else $error("spurious reject");
    a_config_hold: assert property (!wr_cfg |=> $stable(config_byte)) else $error("config moved");
    a_config_store: assert property (wr_cfg |=> config_byte == $past(host_access.wdata))
        else $error("config lost");
    a_config_read: assert property (rd_req && idx == VCR_IDX_CONFIG |=> read_data == config_byte)
        else $error("cfg read");
    a_reserved_read: assert property (rd_req && (idx < VCR_IDX_CONFIG || idx > VCR_IDX_BANK)
        |=> read_data == VCR_RESERVED_BYTE) else $error("reserved read");
    a_low_nibble: assert property (rd_req && idx == VCR_IDX_ADDR_LOW |=> read_data[3:0] == VCR_LOW_NIBBLE)
        else $error("low nibble");
    a_bank_code: assert property (rd_req && idx == VCR_IDX_BANK |=> read_data[7:3] == VCR_BANK_PAD
        && (read_data[2] || read_data[1:0] == 2'h0)) else $error("bank code");
    c_status_read: cover property (rd_req && idx == VCR_IDX_STATUS);
    c_reject: cover property (wr_req && !wr_cfg);
    c_config_write: cover property (wr_cfg);
endmodule : vcr_regs_checker

bind vcr_regs vcr_regs_checker i_vcr_regs_checker (.link_clk(link_clk), .reset_n(reset_n),
    .host_access(host_access), .read_data(read_data), .read_valid(read_valid),
    .reject_flag_set(reject_flag_set), .wel_clear(wel_clear), .config_byte(config_byte));

// ### tb/vcr_host_model.sv
// host side model issuing register accesses on the link clock
`timescale 1ns/1ps
module vcr_host_model
    import vcr_pkg::*;
(
    input wire logic link_clk,
    output vcr_pkg::vcr_access_type host_access,
    input wire logic [7:0] read_data,
    input wire logic read_valid,
    input wire logic reject_flag_set,
    input wire logic wel_clear
);
    initial host_access = '0;
    // released address and data show the inverse, not the last value
    task automatic transfer(input logic w, input logic [31:0] a, input logic [7:0] wd,
        output logic [7:0] rd, output logic rv, output logic rj);
        @(posedge link_clk);
        host_access <= '{valid: 1'b1, write: w, addr: a, wdata: wd};
        @(posedge link_clk);
        host_access <= '{valid: 1'b0, write: w, addr: ~a, wdata: ~wd};
        #1;
        rv = read_valid;
        rj = reject_flag_set & wel_clear;
        rd = read_data;
    endtask : transfer
endmodule : vcr_host_model

// ### tb/vcr_regs_tb.sv
// self-checking bench for the status register bank
`timescale 1ns/1ps
module vcr_regs_tb;
    import vcr_pkg::*;
    logic mclk = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    vcr_event_type core_event = '0;
    vcr_access_type host_access;
    logic [7:0] read_data;
    logic read_valid;
    logic reject_flag_set;
    logic wel_clear;
    logic [7:0] config_byte;
    integer seed = 32'h7D16;
    int miscompares = 0;
    int checks = 0;
    logic [7:0] cfg;
    logic [3:0] tally;
    logic cap, dbl, par, crc, incr;
    logic [27:0] chunk;
    logic [2:0] bank;
    vcr_event_type e;
    logic [7:0] idx_list [11] = '{8'h00, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'hFF};
    vcr_regs i_vcr_regs (.mclk(mclk), .reset_n(reset_n), .link_clk(link_clk), .core_event(core_event),
        .host_access(host_access), .read_data(read_data), .read_valid(read_valid),
        .reject_flag_set(reject_flag_set), .wel_clear(wel_clear), .config_byte(config_byte));
    vcr_host_model i_vcr_host_model (.link_clk(link_clk), .host_access(host_access), .read_data(read_data),
        .read_valid(read_valid), .reject_flag_set(reject_flag_set), .wel_clear(wel_clear));
    always #20 mclk = ~mclk;
    always #24 link_clk = ~link_clk;
    // ****************************************
    // expectation and checks
    // ****************************************
    function automatic logic [7:0] exp_byte(input logic [7:0] i);
        case (i)
            VCR_IDX_CONFIG: exp_byte = cfg;
            VCR_IDX_STATUS: exp_byte = {incr, tally, dbl, par, crc};
            VCR_IDX_ADDR_LOW: exp_byte = {chunk[3:0], 4'h0};
            VCR_IDX_ADDR_MID: exp_byte = chunk[11:4];
            VCR_IDX_ADDR_UPPER: exp_byte = chunk[19:12];
            VCR_IDX_ADDR_TOP: exp_byte = chunk[27:20];
            VCR_IDX_BANK: exp_byte = {5'h00, bank};
            default: exp_byte = 8'hFF;
        endcase
    endfunction : exp_byte
    function automatic void note_event(input vcr_event_type v);
        if (!cfg[0] && (v.ecc_single || v.ecc_double))
        begin
            if (tally != 4'hF)
                tally = tally + 4'h1;
            if (!cap && (cfg[2] ? v.ecc_double : v.ecc_single))
            begin
                cap = 1'b1;
                chunk = v.chunk_addr;
            end
            dbl = dbl | v.ecc_double;
        end
        par = par | v.parity_err;
        crc = crc | v.crc_err | v.boundary_err;
        incr = incr | v.incr_program;
        bank = v.bank_busy ? {1'b1, v.bank_num} : 3'h0;
    endfunction : note_event
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk8
    task automatic access(input logic w, input logic [7:0] i, input logic [7:0] wd);
        logic [7:0] rd;
        logic rv;
        logic rj;
        logic [23:0] hi;
        hi = 24'($random(seed));
        i_vcr_host_model.transfer(w, {hi, i}, wd, rd, rv, rj);
        if (w)
            chk8($sformatf("reject %h", i), {7'h00, i != VCR_IDX_CONFIG}, {7'h00, rj});
        else
        begin
            chk8("read_valid", 8'h01, {7'h00, rv});
            chk8($sformatf("reg %h", i), exp_byte(i), rd);
        end
    endtask : access
    task automatic check_all();
        repeat (25) @(posedge link_clk);
        foreach (idx_list[k])
            access(1'b0, idx_list[k], 8'h00);
        access(1'b0, 8'($random(seed)), 8'h00);
    endtask : check_all
    task automatic fire(input vcr_event_type v);
        vcr_event_type idle;
        idle = '0;
        idle.bank_busy = v.bank_busy;
        idle.bank_num = v.bank_num;
        @(posedge mclk);
        core_event <= v;
        @(posedge mclk);
        core_event <= idle;
        note_event(v);
    endtask : fire
    task automatic do_reset();
        @(posedge mclk);
        reset_n <= 1'b0;
        core_event <= '0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        cfg = VCR_CONFIG_RESET;
        tally = 4'h0;
        {cap, dbl, par, crc, incr} = 5'h00;
        chunk = 28'h0000000;
        bank = 3'h0;
    endtask : do_reset
    task automatic wrap_up();
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial
    begin
        for (int sel = 1; sel >= 0; sel--)
        begin
            do_reset();
            check_all();
            e = '0;
            e.ecc_double = 1'b1;
            e.incr_program = 1'b1;
            fire(e);
            access(1'b1, VCR_IDX_STATUS, 8'hA5);
            cfg = {5'h1F, sel[0], 2'b10};
            access(1'b1, VCR_IDX_CONFIG, cfg);
            e.incr_program = 1'b0;
            repeat (25) @(posedge link_clk);
            e.ecc_single = sel[0];
            e.ecc_double = !sel[0];
            e.chunk_addr = 28'($random(seed));
            fire(e);
            e.ecc_single = !sel[0];
            e.ecc_double = sel[0];
            e.chunk_addr = 28'($random(seed));
            fire(e);
            check_all();
            // random events, no incremental attempt while correction is on
            repeat (24)
            begin
                e = 37'({$random(seed), $random(seed)});
                e.ecc_single = 1'b1;
                e.incr_program = 1'b0;
                fire(e);
            end
            check_all();
        end
        wrap_up();
    end
    initial
    begin
        #200000;
        miscompares++;
        wrap_up();
    end
endmodule : vcr_regs_tb
